// [include/vsg_pkg.sv]
// Constants for the video sync restart and reprogram block
package vsg_pkg;
    localparam int          CNT_W          = 12;
    localparam int          DATA_W         = 12;
    localparam int          ADDR_W         = 4;
    localparam int          CLK_EN_BIT     = 10;
    localparam logic [11:0] CNT_ONE        = 12'h001;
    localparam logic [11:0] CNT_ZERO       = 12'h000;
    // Register indices
    localparam logic [3:0]  REG_STATUS     = 4'h0;
    localparam logic [3:0]  REG_H_END      = 4'h1;
    localparam logic [3:0]  REG_H_BLK_END  = 4'h2;
    localparam logic [3:0]  REG_H_DRV_BEG  = 4'h3;
    localparam logic [3:0]  REG_H_DRV_END  = 4'h4;
    localparam logic [3:0]  REG_V_END      = 4'h5;
    localparam logic [3:0]  REG_V_BLK_END  = 4'h6;
    localparam logic [3:0]  REG_V_DRV_BEG  = 4'h7;
    localparam logic [3:0]  REG_V_DRV_END  = 4'h8;
    localparam logic [3:0]  REG_H_SYN_BEG  = 4'h9;
    localparam logic [3:0]  REG_H_SYN_END  = 4'hA;
    localparam logic [3:0]  REG_V_SYN_BEG  = 4'hB;
    localparam logic [3:0]  REG_V_SYN_END  = 4'hC;
    localparam int          NUM_REGS       = 13;
    // Built-in defaults, counts start at 1
    localparam logic [11:0] DEF_STATUS     = 12'h000;
    localparam logic [11:0] DEF_H_END      = 12'h38E;
    localparam logic [11:0] DEF_H_BLK_END  = 12'h09C;
    localparam logic [11:0] DEF_H_DRV_BEG  = 12'h001;
    localparam logic [11:0] DEF_H_DRV_END  = 12'h05B;
    localparam logic [11:0] DEF_V_END      = 12'h20D;
    localparam logic [11:0] DEF_V_BLK_END  = 12'h028;
    localparam logic [11:0] DEF_V_DRV_BEG  = 12'h001;
    localparam logic [11:0] DEF_V_DRV_END  = 12'h016;
    localparam logic [11:0] DEF_H_SYN_BEG  = 12'h017;
    localparam logic [11:0] DEF_H_SYN_END  = 12'h05A;
    localparam logic [11:0] DEF_V_SYN_BEG  = 12'h007;
    localparam logic [11:0] DEF_V_SYN_END  = 12'h00C;
endpackage : vsg_pkg

// [logic/vsg_sync_gen.sv]
// Sync generator core with clear, vectored restart and live reprogramming
//
// What this block does
// - Clear pulse reloads every timing and status register with its default.
// - Clock-enable bit 10 of status defaults to 0 after clear.
// - Vectored restart leaves all programmed register contents unchanged.
// - First frame after restart: drives start at first clock, end as programmed.
// - From the second clock of the next frame, drives return to programmed start and end times.
// - End lowered below running count: counter runs to 4095 then wraps to 0.
// - Host may finish reprogramming with restart; all counters restart at one.
`timescale 1ns/1ps
module vsg_sync_gen
    import vsg_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock_in,
    input  wire logic                      reset_in,
    // Control
    input  wire logic                      clear_pulse_in,
    input  wire logic                      restart_in,
    // Register load port
    input  wire logic                      load_in,
    input  wire logic [vsg_pkg::ADDR_W-1:0] load_addr_in,
    input  wire logic [vsg_pkg::DATA_W-1:0] load_data_in,
    // Video outputs
    output logic                           hsync_out,
    output logic                           vsync_out,
    output logic                           hblank_out,
    output logic                           vblank_out,
    output logic                           hdrive_out,
    output logic                           vdrive_out,
    output logic                           clock_enabled_out
);
    import vsg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        VSG_NORMAL  = 2'b01,
        VSG_FIRST   = 2'b10
    } vsg_frame_e;

    logic [DATA_W-1:0] regs_q [NUM_REGS];
    logic [DATA_W-1:0] defaults [NUM_REGS];
    logic [CNT_W-1:0]  hcnt_q;
    logic [CNT_W-1:0]  vcnt_q;
    vsg_frame_e        frame_q;
    vsg_frame_e        frame_d;

    assign defaults[REG_STATUS]    = DEF_STATUS;
    assign defaults[REG_H_END]     = DEF_H_END;
    assign defaults[REG_H_BLK_END] = DEF_H_BLK_END;
    assign defaults[REG_H_DRV_BEG] = DEF_H_DRV_BEG;
    assign defaults[REG_H_DRV_END] = DEF_H_DRV_END;
    assign defaults[REG_V_END]     = DEF_V_END;
    assign defaults[REG_V_BLK_END] = DEF_V_BLK_END;
    assign defaults[REG_V_DRV_BEG] = DEF_V_DRV_BEG;
    assign defaults[REG_V_DRV_END] = DEF_V_DRV_END;
    assign defaults[REG_H_SYN_BEG] = DEF_H_SYN_BEG;
    assign defaults[REG_H_SYN_END] = DEF_H_SYN_END;
    assign defaults[REG_V_SYN_BEG] = DEF_V_SYN_BEG;
    assign defaults[REG_V_SYN_END] = DEF_V_SYN_END;

    ////////////////////////////////////////////////////////////////////////
    wire clear_all   = reset_in | clear_pulse_in;
    wire clk_en      = regs_q[REG_STATUS][CLK_EN_BIT];
    wire run         = clk_en & ~clear_all & ~restart_in;
    // Restart shows count one at once, so the first clock is not stale
    wire restart_go  = restart_in & ~clear_all;
    wire show        = clk_en & ~clear_all;
    // Exact compare only: a passed end is missed and the counter wraps
    wire h_at_end    = (hcnt_q == regs_q[REG_H_END]);
    wire v_at_end    = (vcnt_q == regs_q[REG_V_END]);
    wire frame_done  = h_at_end & v_at_end;
    wire [CNT_W-1:0] hcnt_next = h_at_end ? CNT_ONE : hcnt_q + CNT_ONE;
    wire [CNT_W-1:0] vcnt_next = v_at_end ? CNT_ONE : vcnt_q + CNT_ONE;
    wire [CNT_W-1:0] hcnt_d    = restart_go ? CNT_ONE : run ? hcnt_next : hcnt_q;
    wire [CNT_W-1:0] vcnt_d    = restart_go ? CNT_ONE : (run & h_at_end) ? vcnt_next : vcnt_q;
    wire first_frame = restart_go | (frame_q == VSG_FIRST);
    // First frame after restart: drive starts at the first count
    wire [CNT_W-1:0] hdrv_beg = first_frame ? CNT_ONE : regs_q[REG_H_DRV_BEG];
    wire [CNT_W-1:0] vdrv_beg = first_frame ? CNT_ONE : regs_q[REG_V_DRV_BEG];
    wire hsync_d  = (hcnt_d >= regs_q[REG_H_SYN_BEG]) & (hcnt_d <= regs_q[REG_H_SYN_END]);
    wire vsync_d  = (vcnt_d >= regs_q[REG_V_SYN_BEG]) & (vcnt_d <= regs_q[REG_V_SYN_END]);
    wire hblank_d = (hcnt_d <= regs_q[REG_H_BLK_END]);
    wire vblank_d = (vcnt_d <= regs_q[REG_V_BLK_END]);
    wire hdrive_d = (hcnt_d >= hdrv_beg) & (hcnt_d <= regs_q[REG_H_DRV_END]);
    wire vdrive_d = (vcnt_d >= vdrv_beg) & (vcnt_d <= regs_q[REG_V_DRV_END]);

    always_comb begin
        frame_d = frame_q;
        case (frame_q)
            VSG_NORMAL: frame_d = VSG_NORMAL;
            VSG_FIRST:  frame_d = (run & frame_done) ? VSG_NORMAL : VSG_FIRST;
            default:    frame_d = VSG_NORMAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file, loads accepted regardless of clock enable
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (clear_all) begin
                regs_q[i] <= defaults[i];
            end else if (load_in && load_addr_in == ADDR_W'(i)) begin
                regs_q[i] <= load_data_in;
            end
        end
    end

    // Counters; restart keeps registers and reloads counts
    always_ff @(posedge clock_in) begin
        if (clear_all || restart_in) begin
            hcnt_q  <= CNT_ONE;
            vcnt_q  <= CNT_ONE;
            frame_q <= restart_in && !clear_all ? VSG_FIRST : VSG_NORMAL;
        end else begin
            hcnt_q  <= hcnt_d;
            vcnt_q  <= vcnt_d;
            frame_q <= frame_d;
        end
    end

    // Outputs are registered and hold while halted
    always_ff @(posedge clock_in) begin
        if (clear_all) begin
            hsync_out         <= 1'b0;
            vsync_out         <= 1'b0;
            hblank_out        <= 1'b0;
            vblank_out        <= 1'b0;
            hdrive_out        <= 1'b0;
            vdrive_out        <= 1'b0;
            clock_enabled_out <= 1'b0;
        end else begin
            clock_enabled_out <= clk_en;
            if (show) begin
                hsync_out  <= hsync_d;
                vsync_out  <= vsync_d;
                hblank_out <= hblank_d;
                vblank_out <= vblank_d;
                hdrive_out <= hdrive_d;
                vdrive_out <= vdrive_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_clear;
        clear_pulse_in;
    endsequence
    sequence s_restart;
        restart_in && !clear_pulse_in;
    endsequence

    property p_clear_defaults;
        @(posedge clock_in) disable iff (reset_in)
        s_clear |=> regs_q[REG_H_END] == DEF_H_END && regs_q[REG_V_END] == DEF_V_END;
    endproperty
    a_clear_defaults: assert property (p_clear_defaults) else $error("clear missed defaults");

    property p_clear_clk_off;
        @(posedge clock_in) disable iff (reset_in)
        s_clear ##1 !load_in |=> !clock_enabled_out;
    endproperty
    a_clear_clk_off: assert property (p_clear_clk_off) else $error("clock enable not cleared");

    property p_halt_freeze;
        @(posedge clock_in) disable iff (reset_in)
        (!clk_en && !clear_pulse_in && !restart_in) |=> $stable(hcnt_q) && $stable(hsync_out);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved while halted");

    property p_restart_keeps;
        @(posedge clock_in) disable iff (reset_in)
        (s_restart ##0 !load_in) |=> $stable(regs_q[REG_H_END]) && $stable(regs_q[REG_V_END]);
    endproperty
    a_restart_keeps: assert property (p_restart_keeps) else $error("restart altered register");

    property p_restart_counts;
        @(posedge clock_in) disable iff (reset_in)
        s_restart |=> hcnt_q == CNT_ONE && vcnt_q == CNT_ONE && frame_q == VSG_FIRST;
    endproperty
    a_restart_counts: assert property (p_restart_counts) else $error("restart count wrong");

    property p_first_drive;
        @(posedge clock_in) disable iff (reset_in)
        (first_frame && run && hcnt_d == CNT_ONE && regs_q[REG_H_DRV_END] != CNT_ZERO)
            |=> hdrive_out;
    endproperty
    a_first_drive: assert property (p_first_drive) else $error("drive not at first clock");

    property p_frame_return;
        @(posedge clock_in) disable iff (reset_in)
        (first_frame && run && frame_done && !restart_in) |=> frame_q == VSG_NORMAL;
    endproperty
    a_frame_return: assert property (p_frame_return) else $error("first frame not left");

    property p_wrap_past_end;
        @(posedge clock_in) disable iff (reset_in)
        (run && hcnt_q > regs_q[REG_H_END] && hcnt_q != {CNT_W{1'b1}})
            |=> hcnt_q == $past(hcnt_q) + CNT_ONE;
    endproperty
    a_wrap_past_end: assert property (p_wrap_past_end) else $error("passed end not run on");

    property p_run_counts;
        @(posedge clock_in) disable iff (reset_in)
        (run && !h_at_end) |=> hcnt_q == $past(hcnt_q) + CNT_ONE;
    endproperty
    a_run_counts: assert property (p_run_counts) else $error("counter stalled when enabled");

    property p_restart_drive;
        @(posedge clock_in) disable iff (reset_in)
        (s_restart ##0 (clk_en && regs_q[REG_H_DRV_END] != CNT_ZERO
            && regs_q[REG_V_DRV_END] != CNT_ZERO)) |=> hdrive_out && vdrive_out;
    endproperty
    a_restart_drive: assert property (p_restart_drive) else $error("drive off at restart");

    property p_clear_outputs;
        @(posedge clock_in) disable iff (reset_in)
        s_clear |=> !hsync_out && !vsync_out && !hblank_out && !vblank_out
            && !hdrive_out && !vdrive_out;
    endproperty
    a_clear_outputs: assert property (p_clear_outputs) else $error("outputs not cleared");

    property p_normal_start;
        @(posedge clock_in) disable iff (reset_in)
        (frame_q == VSG_NORMAL && run && hcnt_d == CNT_ONE
            && regs_q[REG_H_DRV_BEG] > CNT_ONE) |=> !hdrive_out;
    endproperty
    a_normal_start: assert property (p_normal_start) else $error("drive early in frame");
endmodule : vsg_sync_gen

// [tb/vsg_monitor.sv]
// Receiving-side model that measures line period, sync width and drive width
`timescale 1ns/1ps
module vsg_monitor (
    // Clock
    input  wire logic        clock_in,
    // Video from the generator
    input  wire logic        hsync_in,
    input  wire logic        hdrive_in,
    // Measurements in clocks, and a running count of lines
    output logic      [15:0] period_out,
    output logic      [15:0] width_out,
    output logic      [15:0] drive_out,
    output logic      [15:0] lines_out
);
    logic        hs_q;
    logic        hd_q;
    logic [15:0] since_q;
    logic [15:0] hw_q;
    logic [15:0] dw_q;
    initial begin
        {hs_q, hd_q, since_q, hw_q, dw_q} = '0;
        {period_out, width_out, drive_out, lines_out} = '0;
    end
    always @(posedge clock_in) begin
        hs_q    <= hsync_in;
        hd_q    <= hdrive_in;
        since_q <= (hsync_in && !hs_q) ? 16'h0001 : since_q + 16'h0001;
        hw_q    <= hsync_in ? hw_q + 16'h0001 : 16'h0000;
        dw_q    <= hdrive_in ? dw_q + 16'h0001 : 16'h0000;
        if (hsync_in && !hs_q) begin
            period_out <= since_q;
            lines_out  <= lines_out + 16'h0001;
        end
        if (!hsync_in && hs_q) width_out <= hw_q;
        if (!hdrive_in && hd_q) drive_out <= dw_q;
    end
endmodule : vsg_monitor

// [tb/video_sync_restart_reprogram_tb.sv]
// Self-checking bench for clear, restart and live reprogramming
`timescale 1ns/1ps
module video_sync_restart_reprogram_tb;
    import vsg_pkg::*;
    logic              clock_in, reset_in, clear_pulse_in, restart_in, load_in;
    logic [ADDR_W-1:0] load_addr_in;
    logic [DATA_W-1:0] load_data_in;
    logic              hsync_out, vsync_out, hblank_out, vblank_out;
    logic              hdrive_out, vdrive_out, clock_enabled_out;
    logic [15:0]       period, width, drive, lines;
    int                bad_count, checks_done;
    wire  [6:0]        outs = {hsync_out, vsync_out, hblank_out, vblank_out,
                               hdrive_out, vdrive_out, clock_enabled_out};

    vsg_sync_gen i_vsg_sync_gen (.clock_in(clock_in), .reset_in(reset_in),
        .clear_pulse_in(clear_pulse_in), .restart_in(restart_in), .load_in(load_in),
        .load_addr_in(load_addr_in), .load_data_in(load_data_in), .hsync_out(hsync_out),
        .vsync_out(vsync_out), .hblank_out(hblank_out), .vblank_out(vblank_out),
        .hdrive_out(hdrive_out), .vdrive_out(vdrive_out),
        .clock_enabled_out(clock_enabled_out));
    vsg_monitor i_vsg_monitor (.clock_in(clock_in), .hsync_in(hsync_out),
        .hdrive_in(hdrive_out), .period_out(period), .width_out(width),
        .drive_out(drive), .lines_out(lines));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic load(input logic [3:0] a, input logic [11:0] d);
        @(negedge clock_in);
        load_in      = 1'b1;
        load_addr_in = a;
        load_data_in = d;
    endtask : load
    task automatic load_end;
        @(negedge clock_in);
        load_in = 1'b0;
    endtask : load_end
    task automatic wait_rise(input int n);
        logic [15:0] l0;
        l0 = lines + 16'(n);
        for (int i = 0; i < 6000 && lines !== l0; i++) @(negedge clock_in);
        if (lines !== l0) begin
            bad_count++;
            $display("[ERR] line count expected %0h seen %0h", l0, lines);
        end
    endtask : wait_rise
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_idle;
        check("clk_en after reset", 16'(clock_enabled_out), 16'h0000);
        check("outputs after reset", 16'(outs), 16'h0000);
        load(REG_H_END, 12'h014);
        load(REG_H_SYN_BEG, 12'h005);
        load(REG_H_SYN_END, 12'h008);
        load(REG_H_BLK_END, 12'h004);
        load(REG_H_DRV_BEG, 12'h00A);
        load(REG_H_DRV_END, 12'h00C);
        load(REG_V_END, 12'h004);
        load_end;
        repeat (50) @(negedge clock_in);
        check("frozen outputs", 16'(outs), 16'h0000);
        $display("test idle done");
    endtask : t_idle
    task automatic t_restart;
        load(REG_STATUS, 12'h400);
        load_end;
        repeat (2) @(negedge clock_in);
        check("clk_en on", 16'(clock_enabled_out), 16'h0001);
        @(negedge clock_in) restart_in = 1'b1;
        @(negedge clock_in) restart_in = 1'b0;
        wait_rise(2);
        check("first line drive", drive, 16'h000C);
        wait_rise(1);
        check("line period", period, 16'h0014);
        check("sync width", width, 16'h0004);
        check("first frame drive", drive, 16'h000C);
        wait_rise(6);
        check("later drive", drive, 16'h0003);
        $display("test restart done");
    endtask : t_restart
    task automatic t_overrun;
        wait_rise(1);
        repeat (9) @(negedge clock_in);
        load(REG_H_END, 12'h00C);
        load_end;
        wait_rise(1);
        check("overrun", 16'((period > 16'd4000) && (period < 16'd4200)), 16'h0001);
        wait_rise(1);
        check("period after wrap", period, 16'h000C);
        $display("test overrun done");
    endtask : t_overrun
    task automatic t_blank_load;
        while (hblank_out !== 1'b0) @(negedge clock_in);
        while (hblank_out !== 1'b1) @(negedge clock_in);
        load(REG_H_END, 12'h010);
        load_end;
        wait_rise(2);
        check("period after blank load", period, 16'h0010);
        $display("test blank load done");
    endtask : t_blank_load
    task automatic t_clear;
        @(negedge clock_in) clear_pulse_in = 1'b1;
        @(negedge clock_in) clear_pulse_in = 1'b0;
        repeat (2) @(negedge clock_in);
        check("clk_en after clear", 16'(clock_enabled_out), 16'h0000);
        check("outputs after clear", 16'(outs), 16'h0000);
        load(REG_STATUS, 12'h400);
        load_end;
        wait_rise(3);
        check("default period", period, 16'(DEF_H_END));
        check("default sync", width, 16'(DEF_H_SYN_END - DEF_H_SYN_BEG + 12'h001));
        $display("test clear done");
    endtask : t_clear

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial begin
        {reset_in, clear_pulse_in, restart_in, load_in} = 4'h8;
        load_addr_in = '0;
        load_data_in = '0;
        bad_count    = 0;
        checks_done  = 0;
        repeat (10) @(posedge clock_in);
        @(negedge clock_in) reset_in = 1'b0;
        t_idle();
        t_restart();
        t_overrun();
        t_blank_load();
        t_clear();
        end_of_test();
    end
    initial begin
        #160000;
        bad_count++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : video_sync_restart_reprogram_tb
